// [fwp_core.sv]
// Sector write protection logic behind the serial flash pins.
// Assumes an SPI mode 0 host; reset stands for a power-up, so the
// one-time and persistent bits also return to factory values on it.
`timescale 1ns/1ps
module fwp_core
  import fwp_pkg::*;
#(
  parameter int SECW = 8 // Sector index width; sectors = 2**SECW.
) (
  input  wire logic             clk,      // System clock, 200 MHz.
  input  wire logic             rst,      // Asynchronous reset, high.
  input  wire logic             cs_n,     // Chip select pin, low active.
  input  wire logic             sclk,     // Serial clock pin.
  input  wire logic             mosi,     // Serial data in.
  input  wire logic             wp_n,     // Write protect pin, low active.
  output logic                  miso,     // Serial data out.
  output logic                  miso_oe,  // Data out enable.
  output logic [(1<<SECW)-1:0]  sect_prot, // Sector refuses program/erase.
  output logic                  scheme_sel, // Scheme select bit.
  output logic                  prog_fail  // Program fail flag.
);
  localparam int NSEC = 1 << SECW; // Number of sectors.

  fwp_pins_s  pin;          // Synchronised pins.
  fwp_rx_s    rx;           // Receiver events.
  fwp_state_e state_ff;     // Command phase.
  logic [7:0] opc_ff;       // Current opcode.
  logic [23:0] addr_ff;     // Address bytes.
  logic [15:0] dat_ff;      // Last two bytes received.
  logic        wel_ff;      // Write enable latch.
  logic        status_write_disable_ff;     // Status write disable.
  logic [3:0]  bp_ff;       // Block protect level.
  logic [15:0] lock_ff;     // Method lock register.
  logic        frz_ff;      // Freeze bit, 1 = unlocked.
  logic        ovr_ff;      // Override, 1 = persistent bits count.
  logic [NSEC-1:0] spb_ff;  // Persistent sector locks.
  logic [NSEC-1:0] dpb_ff;  // Volatile sector locks.
  logic [15:0] tx_ff;       // Outgoing bits.
  logic [SECW-1:0] sec;     // Addressed sector.
  logic [SECW:0]   bp_cnt;  // Sectors covered by the level.
  logic ex;                 // Frame ended cleanly in body phase.
  logic do_sel, do_glk, do_gul, do_lrw, do_frz, do_plp, do_ple;
  logic do_vlw, do_wrsr, do_ovr;
  logic [15:0] lr_new;      // Lock value after programming.
  logic lr_bad;             // Lock write must not take effect.
  logic pl_bad;             // Persistent change refused.
  logic bp_lock;            // Level bits are frozen.

  // Reset levels match the idle pins (chip select and protect high, clock and
  // data low), so the edge detectors see no false serial clock edge after reset.
  fwp_sync #(
    .W   (4),
    .RST (4'h9)
  ) u_sync (
    .clk  (clk),
    .rst  (rst),
    .din  ({cs_n, sclk, mosi, wp_n}),
    .dout (pin)
  );

  fwp_spi_rx u_rx (
    .clk (clk),
    .rst (rst),
    .pin (pin),
    .rx  (rx)
  );

  // Opcodes that the sector scheme owns are only known once it is on.
  function automatic logic known(input logic [7:0] op, input logic sel);
    logic per_sec;
    per_sec = (op == OP_GLOCK) || (op == OP_GUNLK) || (op == OP_LRWR) ||
              (op == OP_LRRD) || (op == OP_FRZSET) || (op == OP_FRZRD) ||
              (op == OP_PLPROG) || (op == OP_PLERA) || (op == OP_PLRD) ||
              (op == OP_VLWR) || (op == OP_VLRD) || (op == OP_OVRWR);
    known = (per_sec && sel) || (op == OP_WRITE_ENABLE_COMMAND) || (op == OP_RDSR) ||
            (op == OP_WRSR) || (op == OP_RDSCUR) || (op == OP_SEL);
  endfunction : known

  assign sec = addr_ff[SEC_LSB +: SECW];
  assign ex  = rx.cs_rise && rx.boundary && (state_ff == FWP_BODY);

  // Write strobes; each needs the enable latch and an exact byte count.
  assign do_sel  = ex && wel_ff && opc_ff == OP_SEL && rx.idx == LEN_OPC;
  assign do_glk  = ex && wel_ff && opc_ff == OP_GLOCK && rx.idx == LEN_OPC;
  assign do_gul  = ex && wel_ff && opc_ff == OP_GUNLK && rx.idx == LEN_OPC;
  assign do_frz  = ex && wel_ff && opc_ff == OP_FRZSET && rx.idx == LEN_OPC;
  assign do_ple  = ex && wel_ff && opc_ff == OP_PLERA && rx.idx == LEN_OPC;
  assign do_plp  = ex && wel_ff && opc_ff == OP_PLPROG && rx.idx == LEN_ADDR;
  assign do_vlw  = ex && wel_ff && opc_ff == OP_VLWR && rx.idx == LEN_AD_D;
  assign do_lrw  = ex && wel_ff && opc_ff == OP_LRWR && rx.idx == LEN_WORD;
  assign do_wrsr = ex && wel_ff && opc_ff == OP_WRSR && rx.idx == LEN_BYTE;
  assign do_ovr  = ex && wel_ff && opc_ff == OP_OVRWR && rx.idx == LEN_BYTE;

  // Lock bits only program towards zero.
  assign lr_new = lock_ff & dat_ff;
  assign lr_bad = !lock_ff[LR_PW_BIT] || !lock_ff[LR_SOLID_BIT] ||
                  (!lr_new[LR_PW_BIT] && !lr_new[LR_SOLID_BIT]);
  assign pl_bad  = !frz_ff;
  assign bp_lock = status_write_disable_ff && !pin.wp_n;

  // Command phase tracking; unknown opcodes are dropped whole.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= FWP_IDLE;
      opc_ff   <= '0;
    end else begin
      case (state_ff)
        FWP_IDLE: begin
          if (!pin.cs_n) state_ff <= FWP_OPC;
        end
        FWP_OPC: begin
          if (rx.cs_rise) begin
            state_ff <= FWP_IDLE;
          end else if (rx.byte_done) begin
            opc_ff   <= rx.data;
            state_ff <= known(rx.data, scheme_sel) ? FWP_BODY : FWP_DROP;
          end
        end
        default: begin
          if (rx.cs_rise) state_ff <= FWP_IDLE;
        end
      endcase
    end
  end

  // Address and data capture.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_ff <= '0;
      dat_ff  <= '0;
    end else if (rx.byte_done) begin
      dat_ff <= {dat_ff[7:0], rx.data};
      if (rx.idx >= IDX_A_LO && rx.idx <= IDX_A_HI) addr_ff <= {addr_ff[15:0], rx.data};
    end
  end

  // Write enable latch: any completed write attempt consumes it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wel_ff <= 1'b0;
    end else if (ex && opc_ff == OP_WRITE_ENABLE_COMMAND && rx.idx == LEN_OPC) begin
      wel_ff <= 1'b1;
    end else if (do_sel | do_glk | do_gul | do_frz | do_ple | do_plp |
                 do_vlw | do_lrw | do_wrsr | do_ovr) begin
      wel_ff <= 1'b0;
    end
  end

  // Scheme select is one-time: it can only ever be set.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scheme_sel <= 1'b0;
    end else if (do_sel) begin
      scheme_sel <= 1'b1;
    end
  end

  // Status byte: level bits held while the disable bit and pin agree.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_write_disable_ff <= 1'b0;
      bp_ff   <= '0;
    end else if (do_wrsr && !bp_lock) begin
      status_write_disable_ff <= dat_ff[SR_STATUS_WRITE_DISABLE_BIT];
      bp_ff   <= dat_ff[SR_BP_LSB +: 4];
    end
  end

  // Method lock and freeze bit. Selecting password freezes at once.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lock_ff <= LR_RST;
      frz_ff  <= 1'b1;
    end else begin
      if (do_lrw && !lr_bad) begin
        lock_ff <= lr_new;
        if (!lr_new[LR_PW_BIT]) frz_ff <= 1'b0;
      end else if (do_frz) begin
        frz_ff <= 1'b0;
      end
    end
  end

  // Override bit: volatile, comes up with persistent bits counted.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ovr_ff <= 1'b1;
    end else if (do_ovr) begin
      ovr_ff <= dat_ff[0];
    end
  end

  // Program fail: a refused lock write or persistent change sets it; any other lock, persistent, volatile or status write clears it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prog_fail <= 1'b0;
    end else if ((do_lrw && lr_bad) || ((do_plp || do_ple) && pl_bad)) begin
      prog_fail <= 1'b1;
    end else if (do_lrw || do_plp || do_ple || do_vlw || do_wrsr) begin
      prog_fail <= 1'b0;
    end
  end

  // Sectors covered by the level: top 2**(level-1), capped at all.
  always_comb begin
    bp_cnt = '0;
    if (bp_ff != 4'h0) bp_cnt = (SECW+1)'(1) << (bp_ff - 4'h1);
    if (int'(bp_ff) > SECW + 1) bp_cnt = (SECW+1)'(NSEC);
  end

  // Per-sector lock bits and the resulting protection.
  for (genvar i = 0; i < NSEC; i++) begin : g_sec
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        spb_ff[i]    <= 1'b0;
        dpb_ff[i]    <= 1'b1;
        sect_prot[i] <= 1'b1;
      end else begin
        if (do_ple && !pl_bad) begin
          spb_ff[i] <= 1'b0;
        end else if (do_plp && !pl_bad && sec == SECW'(i)) begin
          spb_ff[i] <= 1'b1;
        end
        if (do_glk) begin
          dpb_ff[i] <= 1'b1;
        end else if (do_gul) begin
          dpb_ff[i] <= 1'b0;
        end else if (do_vlw && sec == SECW'(i)) begin
          dpb_ff[i] <= |dat_ff[7:0];
        end
        if (scheme_sel) begin
          sect_prot[i] <= !pin.wp_n || dpb_ff[i] || (spb_ff[i] && ovr_ff);
        end else begin
          sect_prot[i] <= ((SECW+1)'(i) + bp_cnt) >= (SECW+1)'(NSEC);
        end
      end
    end
  end

  // Read data: loaded after each byte, shifted out on falling edges.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_ff   <= '0;
      miso    <= 1'b0;
      miso_oe <= 1'b0;
    end else if (rx.cs_rise || pin.cs_n) begin
      miso_oe <= 1'b0;
    end else if (rx.byte_done) begin
      if (rx.idx == 3'h0) begin
        miso_oe <= (rx.data == OP_RDSR) || (rx.data == OP_RDSCUR) ||
                   (known(rx.data, scheme_sel) &&
                    (rx.data == OP_LRRD || rx.data == OP_FRZRD ||
                     rx.data == OP_PLRD || rx.data == OP_VLRD));
      end
      if ((rx.idx == 3'h0 ? rx.data : opc_ff) == OP_RDSR) begin
        tx_ff <= {status_write_disable_ff, 1'b0, bp_ff, 2'b00, 8'h00};
      end else if ((rx.idx == 3'h0 ? rx.data : opc_ff) == OP_RDSCUR) begin
        tx_ff <= {scheme_sel, 1'b0, prog_fail, 5'h00, 8'h00};
      end else if ((rx.idx == 3'h0 ? rx.data : opc_ff) == OP_FRZRD) begin
        tx_ff <= {7'h00, frz_ff, 8'h00};
      end else if ((rx.idx == 3'h0 ? rx.data : opc_ff) == OP_LRRD && !rx.idx[0]) begin
        tx_ff <= lock_ff;
      end else if (rx.idx >= IDX_DUMY && opc_ff == OP_PLRD) begin
        tx_ff <= {spb_ff[sec] ? BYTE_SET : BYTE_CLR, 8'h00};
      end else if (rx.idx >= IDX_DUMY && opc_ff == OP_VLRD) begin
        tx_ff <= {dpb_ff[sec] ? BYTE_SET : BYTE_CLR, 8'h00};
      end
    end else if (rx.sclk_fall) begin
      miso  <= tx_ff[15];
      tx_ff <= {tx_ff[14:0], 1'b0};
    end
  end

  a_sel_sticky: assert property (@(posedge clk) disable iff (rst)
    $past(scheme_sel) |-> scheme_sel) else $error("select bit cleared");

  a_wp_all: assert property (@(posedge clk) disable iff (rst)
    scheme_sel && !pin.wp_n |=> &sect_prot) else $error("pin low left sector open");

  a_gang_unlk: assert property (@(posedge clk) disable iff (rst)
    do_gul |=> dpb_ff == '0) else $error("gang unlock left locks");

  a_lr_abort: assert property (@(posedge clk) disable iff (rst)
    do_lrw && !lr_new[LR_PW_BIT] && !lr_new[LR_SOLID_BIT] |=> $stable(lock_ff) && prog_fail)
    else $error("dual method write took effect");

  a_lr_frozen: assert property (@(posedge clk) disable iff (rst)
    do_lrw && !(lock_ff[LR_PW_BIT] && lock_ff[LR_SOLID_BIT]) |=> $stable(lock_ff) ##0 prog_fail)
    else $error("locked method register changed");

  a_frz_spb: assert property (@(posedge clk) disable iff (rst)
    (do_plp || do_ple) && !frz_ff |=> $stable(spb_ff) && prog_fail)
    else $error("frozen persistent bits changed");

  a_bp_guard: assert property (@(posedge clk) disable iff (rst)
    do_wrsr && status_write_disable_ff && !pin.wp_n |=> $stable(bp_ff)) else $error("level bits written");

  a_blk_mode: assert property (@(posedge clk) disable iff (rst)
    !rst && !scheme_sel && bp_ff == 4'h0 ##1 !scheme_sel |-> sect_prot == '0)
    else $error("block mode protected with level zero");

  a_sel_frame: assert property (@(posedge clk) disable iff (rst)
    rx.cs_rise && !rx.boundary |=> $stable(scheme_sel)) else $error("select on ragged frame");
endmodule : fwp_core

// [fwp_core_tb.sv]
// Self-checking bench for the sector write protection block.
// Assumes the host model drives the serial pins; the bench drives reset and wp_n.
`timescale 1ns/1ps
module fwp_core_tb;
  import fwp_pkg::*;
  localparam int LIMIT = 80000; // Cycle ceiling for the whole run.
  logic         clk;         // System clock.
  logic         rst;         // Reset, high active.
  logic         wp_n;        // Write protect pin.
  logic         cs_n;        // Chip select.
  logic         sclk;        // Serial clock.
  logic         mosi;        // Serial data in.
  logic         miso;        // Serial data out.
  logic         miso_oe;     // Data out enable.
  logic [255:0] sect_prot;   // Per-sector protection.
  logic         scheme_sel;  // Scheme select bit.
  logic         prog_fail;   // Program fail flag.
  logic [7:0]   rx;          // Last byte read back.
  int           failures;    // Mismatch count.
  int           comparisons; // Comparison count.
  int           cycles;      // Timeout counter.

  fwp_core dut_u (.clk(clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .mosi(mosi),
    .wp_n(wp_n), .miso(miso), .miso_oe(miso_oe), .sect_prot(sect_prot),
    .scheme_sel(scheme_sel), .prog_fail(prog_fail));
  fwp_host host_u (.clk(clk), .miso(miso), .miso_oe(miso_oe), .cs_n(cs_n), .sclk(sclk),
    .mosi(mosi));

  // The clock toggles every half period of 2.5 ns.
  always #2.5 clk = ~clk;

  // A hang is cut short here and counted as a mismatch.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      failures++;
      conclude();
    end
  end

  task automatic conclude();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude

  task automatic chk(input logic [255:0] got, input logic [255:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic op(input logic [47:0] tx, input int nb);
    host_u.frame(tx, nb * 8, rx);
  endtask : op

  // Every write goes behind its own write enable frame.
  task automatic wop(input logic [47:0] tx, input int nb);
    op(OP_WRITE_ENABLE_COMMAND, 1);
    op(tx, nb);
  endtask : wop

  // Reset stands for a power-up; it is held four cycles.
  task automatic do_reset();
    @(posedge clk) rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : do_reset

  task automatic t_reset();
    chk(scheme_sel, 1'b0);
    chk(sect_prot, '0);
    op({OP_RDSCUR, 8'h00}, 2);
    chk(rx, 8'h00);
    chk(miso_oe, 1'b0);
    $display("test reset done");
  endtask : t_reset

  // Level 1 guards the top sector; the disable bit with the pin low freezes it.
  task automatic t_block();
    wop({OP_WRSR, 8'h84}, 2);
    chk(sect_prot, 256'h1 << 255);
    @(posedge clk) wp_n <= 1'b0;
    wop({OP_WRSR, 8'h08}, 2);
    chk(sect_prot, 256'h1 << 255);
    wop(OP_GLOCK, 1);
    chk(sect_prot, 256'h1 << 255);
    @(posedge clk) wp_n <= 1'b1;
    wop({OP_WRSR, 8'h04}, 2);
    op({OP_RDSR, 8'h00}, 2);
    chk(rx, 8'h04);
    $display("test block done");
  endtask : t_block

  // A ragged select is ignored; a whole one starts sector mode fully locked.
  task automatic t_select();
    op(OP_WRITE_ENABLE_COMMAND, 1);
    host_u.frame({OP_SEL, 1'b0}, 9, rx);
    chk(scheme_sel, 1'b0);
    wop(OP_SEL, 1);
    chk(scheme_sel, 1'b1);
    chk(sect_prot, '1);
    wop(OP_GUNLK, 1);
    chk(sect_prot, '0);
    @(posedge clk) wp_n <= 1'b0;
    repeat (8) @(posedge clk);
    chk(sect_prot, '1);
    @(posedge clk) wp_n <= 1'b1;
    op({OP_RDSCUR, 8'h00}, 2);
    chk(rx, 8'h80);
    $display("test select done");
  endtask : t_select

  task automatic t_volatile();
    op({OP_VLRD, 24'h005000, 16'h0000}, 6);
    chk(rx, BYTE_CLR);
    wop(OP_GLOCK, 1);
    op({OP_VLRD, 24'h005000, 16'h0000}, 6);
    chk(rx, BYTE_SET);
    wop({OP_VLWR, 24'h005000, 8'h00}, 5);
    chk(sect_prot, ~(256'h1 << 5));
    wop(OP_GUNLK, 1);
    $display("test volatile done");
  endtask : t_volatile

  task automatic t_persist();
    wop({OP_PLPROG, 24'h003000}, 4);
    chk(sect_prot, 256'h1 << 3);
    op({OP_PLRD, 24'h003000, 16'h0000}, 6);
    chk(rx, BYTE_SET);
    op({OP_PLRD, 24'h002000, 16'h0000}, 6);
    chk(rx, BYTE_CLR);
    wop({OP_OVRWR, 8'h00}, 2);
    chk(sect_prot, '0);
    wop({OP_OVRWR, 8'h01}, 2);
    wop(OP_PLERA, 1);
    chk(sect_prot, '0);
    $display("test persist done");
  endtask : t_persist

  task automatic t_method();
    op({OP_LRRD, 16'h0000}, 3);
    chk(rx, LR_RST[7:0]);
    op({OP_FRZRD, 8'h00}, 2);
    chk(rx, 8'h01);
    wop({OP_LRWR, 16'hFFF9}, 3);
    op({OP_LRRD, 16'h0000}, 3);
    chk(rx, 8'hFF);
    wop({OP_LRWR, 16'hFFFD}, 3);
    op({OP_LRRD, 16'h0000}, 3);
    chk(rx, 8'hFD);
    wop({OP_LRWR, 16'hFFFB}, 3);
    op({OP_LRRD, 16'h0000}, 3);
    chk(rx, 8'hFD);
    chk(prog_fail, 1'b1);
    wop(OP_FRZSET, 1);
    op({OP_FRZRD, 8'h00}, 2);
    chk(rx, 8'h00);
    wop({OP_VLWR, 24'h000000, 8'hFF}, 5);
    chk(prog_fail, 1'b0);
    wop({OP_PLPROG, 24'h002000}, 4);
    chk(prog_fail, 1'b1);
    chk(sect_prot, 256'h1);
    do_reset();
    // Power-up leaves block mode, so the freeze read needs the select again.
    wop(OP_SEL, 1);
    op({OP_FRZRD, 8'h00}, 2);
    chk(rx, 8'h01);
    $display("test method done");
  endtask : t_method

  task automatic t_password();
    wop(OP_SEL, 1);
    wop({OP_LRWR, 16'hFFFB}, 3);
    op({OP_FRZRD, 8'h00}, 2);
    chk(rx, 8'h00);
    wop({OP_PLPROG, 24'h001000}, 4);
    chk(prog_fail, 1'b1);
    $display("test password done");
  endtask : t_password

  // Main sequence: every input has a value at time zero, then reset for four cycles.
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    wp_n = 1'b1;
    failures = 0;
    comparisons = 0;
    cycles = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset();
    t_block();
    t_select();
    t_volatile();
    t_persist();
    t_method();
    t_password();
    conclude();
  end
endmodule : fwp_core_tb

// [fwp_host.sv]
// Host model that frames SPI mode 0 commands towards the protection block.
// Assumes the bench clock of 200 MHz; the serial clock period is 16 such cycles.
`timescale 1ns/1ps
module fwp_host (
  input  wire logic clk,  // System clock.
  input  wire logic miso, // Data from the block.
  input  wire logic miso_oe, // High while the block drives miso.
  output logic      cs_n, // Chip select, low active.
  output logic      sclk, // Serial clock, still outside frames.
  output logic      mosi  // Data to the block.
);
  // Pins start idle, with chip select high and the clock low.
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end

  // One frame: opcode and body in one chip select window, MSB first.
  // Read data is sampled on the rising serial edge, as a real master would.
  task automatic frame(input logic [47:0] tx, input int nbits, output logic [7:0] rx);
    int i;
    rx = 8'h00;
    @(posedge clk) cs_n <= 1'b0;
    repeat (8) @(posedge clk);
    for (i = 0; i < nbits; i++) begin
      mosi <= tx[nbits-1-i];
      repeat (8) @(posedge clk);
      sclk <= 1'b1;
      // A released line has no pull, so it reads as the inverse of the held bit.
      rx = {rx[6:0], miso_oe ? miso : ~miso};
      repeat (8) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (8) @(posedge clk);
    cs_n <= 1'b1;
    // The data line is left at the inverse level, so that stale bits are never reused.
    mosi <= ~mosi;
    // The gap covers the command's execution and more than two serial periods.
    repeat (40) @(posedge clk);
  endtask : frame
endmodule : fwp_host

// [fwp_pkg.sv]
// Constants, types and opcodes for the flash sector write protection block.
// Assumes an SPI mode 0 host, MSB first, one bit per clock on the data pin.
package fwp_pkg;
  localparam logic [7:0] OP_WRITE_ENABLE_COMMAND   = 8'h06; // Write enable.
  localparam logic [7:0] OP_RDSR   = 8'h05; // Status read.
  localparam logic [7:0] OP_WRSR   = 8'h01; // Status write.
  localparam logic [7:0] OP_RDSCUR = 8'h2B; // Security read.
  localparam logic [7:0] OP_SEL    = 8'h68; // Scheme select.
  localparam logic [7:0] OP_GLOCK  = 8'h7E; // Gang lock all.
  localparam logic [7:0] OP_GUNLK  = 8'h98; // Gang unlock all.
  localparam logic [7:0] OP_LRWR   = 8'h2C; // Method lock write.
  localparam logic [7:0] OP_LRRD   = 8'h2D; // Method lock read.
  localparam logic [7:0] OP_FRZSET = 8'hA6; // Freeze set.
  localparam logic [7:0] OP_FRZRD  = 8'hA7; // Freeze read.
  localparam logic [7:0] OP_PLPROG = 8'hE3; // Persistent program.
  localparam logic [7:0] OP_PLERA  = 8'hE4; // Persistent erase all.
  localparam logic [7:0] OP_PLRD   = 8'hE2; // Persistent read.
  localparam logic [7:0] OP_VLWR   = 8'hE1; // Volatile write.
  localparam logic [7:0] OP_VLRD   = 8'hE0; // Volatile read.
  localparam logic [7:0] OP_OVRWR  = 8'hE5; // Override write.
  localparam int SCUR_SEL_BIT  = 7; // Scheme select in security byte.
  localparam int SCUR_FAIL_BIT = 5; // Program fail in security byte.
  localparam int SR_STATUS_WRITE_DISABLE_BIT   = 7; // Status write disable.
  localparam int SR_BP_LSB     = 2; // Lowest level bit.
  localparam int LR_PW_BIT     = 2; // Password method bit.
  localparam int LR_SOLID_BIT  = 1; // Solid method bit.
  localparam int SEC_LSB       = 12; // Sector index starts here.
  localparam logic [15:0] LR_RST   = 16'hFFFF; // Lock register factory value.
  localparam logic [7:0]  BYTE_SET = 8'hFF; // Lock read as set.
  localparam logic [7:0]  BYTE_CLR = 8'h00; // Lock read as clear.
  localparam logic [2:0] LEN_OPC  = 3'h1; // Opcode only.
  localparam logic [2:0] LEN_BYTE = 3'h2; // Opcode and one byte.
  localparam logic [2:0] LEN_WORD = 3'h3; // Opcode and two bytes.
  localparam logic [2:0] LEN_ADDR = 3'h4; // Opcode and address.
  localparam logic [2:0] LEN_AD_D = 3'h5; // Address and data.
  localparam logic [2:0] IDX_A_LO = 3'h1; // First address byte.
  localparam logic [2:0] IDX_A_HI = 3'h3; // Last address byte.
  localparam logic [2:0] IDX_DUMY = 3'h4; // Dummy byte index.
  // Pins as seen by the block after synchronising.
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic mosi;
    logic wp_n;
  } fwp_pins_s;
  // Events from the serial receiver.
  typedef struct packed {
    logic       byte_done; // A byte has arrived.
    logic       cs_rise;   // Frame ended.
    logic       sclk_fall; // Falling clock edge.
    logic       boundary;  // Frame ended on a byte edge.
    logic [2:0] idx;       // Byte index, or byte count at frame end.
    logic [7:0] data;      // Received byte.
  } fwp_rx_s;
  // Command phase, Gray coded along idle, opcode, body.
  typedef enum logic [1:0] {
    FWP_IDLE = 2'b00,
    FWP_OPC  = 2'b01,
    FWP_BODY = 2'b11,
    FWP_DROP = 2'b10
  } fwp_state_e;
endpackage : fwp_pkg

// [fwp_spi_rx.sv]
// Serial receiver: finds clock edges, frames bytes and counts them.
// Assumes synchronised pins and a serial clock well below clk / 4.
`timescale 1ns/1ps
module fwp_spi_rx
  import fwp_pkg::*;
(
  input  wire logic      clk,  // System clock.
  input  wire logic      rst,  // Asynchronous reset.
  input  wire fwp_pins_s pin,  // Synchronised pins.
  output fwp_rx_s        rx    // Registered events.
);
  logic       sclk_q_ff; // Previous serial clock.
  logic       cs_q_ff;   // Previous chip select.
  logic [2:0] bit_ff;    // Bits of the current byte.
  logic [6:0] sh_ff;     // Bits gathered so far.
  logic [2:0] cnt_ff;    // Whole bytes in this frame, saturating.
  logic       rise;      // Rising serial clock.

  assign rise = pin.sclk & ~sclk_q_ff;

  // Bits shift in on the rising edge; a byte counts once all eight are in.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_q_ff <= 1'b0;
      cs_q_ff   <= 1'b1;
      bit_ff    <= '0;
      sh_ff     <= '0;
      cnt_ff    <= '0;
      rx        <= '0;
    end else begin
      sclk_q_ff    <= pin.sclk;
      cs_q_ff      <= pin.cs_n;
      rx.byte_done <= 1'b0;
      rx.cs_rise   <= pin.cs_n & ~cs_q_ff;
      rx.sclk_fall <= ~pin.sclk & sclk_q_ff & ~pin.cs_n;
      if (pin.cs_n & ~cs_q_ff) begin
        rx.boundary <= (bit_ff == 3'h0);
        rx.idx      <= cnt_ff;
      end
      if (pin.cs_n) begin
        bit_ff <= '0;
        cnt_ff <= '0;
      end else if (rise) begin
        bit_ff <= bit_ff + 3'h1;
        sh_ff  <= {sh_ff[5:0], pin.mosi};
        if (bit_ff == 3'h7) begin
          rx.byte_done <= 1'b1;
          rx.data      <= {sh_ff, pin.mosi};
          rx.idx       <= cnt_ff;
          if (cnt_ff != 3'h7) cnt_ff <= cnt_ff + 3'h1;
        end
      end
    end
  end
endmodule : fwp_spi_rx

// [fwp_sync.sv]
// Two flip-flop synchroniser for a group of pins.
// Assumes its inputs are asynchronous to clk.
`timescale 1ns/1ps
module fwp_sync #(
  parameter int         W   = 4,  // Number of pins.
  parameter logic [W-1:0] RST = '1 // Idle level of each pin.
) (
  input  wire logic         clk,  // System clock.
  input  wire logic         rst,  // Asynchronous reset.
  input  wire logic [W-1:0] din,  // Raw pins.
  output logic      [W-1:0] dout  // Synchronised pins.
);
  logic [W-1:0] meta_ff; // First stage, read only by the second.

  // Only the second stage is visible, so metastability stays contained.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= RST;
      dout    <= RST;
    end else begin
      meta_ff <= din;
      dout    <= meta_ff;
    end
  end
endmodule : fwp_sync
